// ### srw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module srw_host_model (
   // Serial write lines
   output logic shiftClk,
   output logic shiftDataIn,
   output logic portSelectN
);
   initial begin
      shiftClk = 1'b0;
      shiftDataIn = 1'b1;
      portSelectN = 1'b1;
   end
   // Shifts bits n-1 down to 0; select stays low afterwards when hold is set
   task automatic send(input logic [63:0] word, input int n, input bit hold);
      portSelectN = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         shiftDataIn = word[i];
         #62.5 shiftClk = 1'b1;
         #62.5 shiftClk = 1'b0;
      end
      // A held select lets the next frame drive the data line at once
      if (!hold) begin
         #62.5 portSelectN = 1'b1;
         // Released line must not keep showing the last bit
         shiftDataIn = ~shiftDataIn;
      end
   endtask
endmodule // srw_host_model
`default_nettype wire

// ### srw_params.svh
`ifndef SRW_PARAMS_SVH
`define SRW_PARAMS_SVH

// Frame layout, most significant bit first
`define SRW_FRAME_BITS      32
`define SRW_HEADER_BITS     12
`define SRW_ADDR_BITS       4
`define SRW_DATA_BITS       16
`define SRW_HEADER          12'h001
`define SRW_HEADER_MSB      31
`define SRW_HEADER_LSB      20
`define SRW_ADDR_MSB        19
`define SRW_ADDR_LSB        16
`define SRW_DATA_MSB        15
`define SRW_DATA_LSB        0

// Register addresses
`define SRW_ADDR_CAL        4'h0
`define SRW_ADDR_CFG        4'h1
`define SRW_ADDR_IOFS       4'h2
`define SRW_ADDR_IGAIN      4'h3
`define SRW_ADDR_EXTCFG     4'h9
`define SRW_ADDR_QOFS       4'hA
`define SRW_ADDR_QGAIN      4'hB
`define SRW_ADDR_FINE       4'hE
`define SRW_ADDR_COARSE     4'hF

// Default states
`define SRW_DEF_CAL         16'h7FFF
`define SRW_DEF_CFG         16'hB2FF
`define SRW_DEF_OFS         16'h007F
`define SRW_DEF_GAIN        16'h807F
`define SRW_DEF_EXTCFG      16'h03FF
`define SRW_DEF_FINE        16'h00FF
`define SRW_DEF_COARSE      16'h007F
`define SRW_DEF_NONE        16'h0000

// Field positions
`define SRW_CAL_START_BIT   15
`define SRW_CFG_OUTCLK_BIT  13
`define SRW_CFG_DUTY_BIT    12
`define SRW_CFG_PHASE_BIT   11
`define SRW_CFG_SDR_BIT     10
`define SRW_CFG_SWING_BIT   9
`define SRW_CFG_EDGE_BIT    8
`define SRW_OFS_MAG_MSB     15
`define SRW_OFS_MAG_LSB     8
`define SRW_OFS_SIGN_BIT    7
`define SRW_GAIN_MSB        15
`define SRW_GAIN_LSB        7
`define SRW_FINE_MSB        15
`define SRW_FINE_LSB        8

`endif

// ### srw_pkg.sv
`include "srw_params.svh"

package srw_pkg;
   typedef logic [`SRW_ADDR_BITS-1:0] srw_addr_t;
   typedef logic [`SRW_DATA_BITS-1:0] srw_word_t;
   typedef logic [`SRW_ADDR_BITS+`SRW_DATA_BITS-1:0] srw_frame_t;

   // Control mode sequence: pin mode, one-cycle default load, extended mode
   typedef enum logic [1:0] {
      SRW_MODE_PIN  = 2'b00,
      SRW_MODE_LOAD = 2'b01,
      SRW_MODE_EXT  = 2'b11
   } srw_mode_e;
endpackage

// ### srw_serial_port.sv
// Behaviour
// - Serial writes take effect only in extended control mode.
// - Serial data is sampled on each rising shift clock edge while select is low.
// - Each write is a 32-bit frame, most significant bit first.
// - Frame opens with eleven zeros then a one.
// - Header is followed by 4-bit address, then 16-bit value.
// - Next frame may start at the 33rd clock without releasing select.
// - Register contents have no effect outside extended control mode.
// - Nine write-only registers decoded; remaining addresses reserved.
// - Calibration bit 15 set starts a calibration like the pin.
// - Bit 13 one gives one clock and over-range; zero gives second clock.
// - Bit 12 enables duty-cycle stabilizer; zero bypasses it.
// - Double-rate bit 11 zero aligns clock edges; one places them mid-cell.
// - Bit 10 zero selects double-rate; one selects single-rate output.
// - Bit 9 one gives standard swing, zero reduced swing.
// - Single-rate bit 8 picks rising or falling output clock edge.
// - Double-rate bit 8 one non-demultiplexed, zero 1:2 demultiplexed.
// - I offset: magnitude bits 15:8, sign bit 7, ones in 6:0.
// - Entering extended mode loads every register with its default.
`timescale 1ns/1ps
`default_nettype none
`include "srw_params.svh"

module srw_serial_port #(
   parameter int FRAME_BITS = `SRW_FRAME_BITS
) (
   // System clock and reset
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   // Serial write port
   input  wire logic                shiftClk,
   input  wire logic                shiftDataIn,
   input  wire logic                portSelectN,
   // Mode and pin-mode controls
   input  wire logic                extendedCtrlN,
   input  wire logic                edgeSelectPin,
   input  wire logic                swingSelectPin,
   // Calibration request
   output logic                     calStart,
   // Output configuration
   output logic                     singleOutclkSel,
   output logic                     dutyStabilizerEn,
   output logic                     doubleRateClkPhase,
   output logic                     singleRateSel,
   output logic                     outputSwingSel,
   output logic                     edgeDemuxSel,
   // Channel offset and gain
   output logic [7:0]               iOffsetMag,
   output logic                     iOffsetNeg,
   output logic [8:0]               iGainAdjust,
   output logic [7:0]               qOffsetMag,
   output logic                     qOffsetNeg,
   output logic [8:0]               qGainAdjust,
   // Raw words of the remaining registers; fine phase gives bits 15:8 only
   output srw_pkg::srw_word_t       extConfigWord,
   output logic [7:0]               phaseFine,
   output srw_pkg::srw_word_t       phaseCoarseWord,
   // Status
   output logic                     extendedActive,
   output logic                     writeDone
);
   import srw_pkg::*;

   generate
      if (FRAME_BITS != `SRW_FRAME_BITS) begin : gBadFrame
         $error("srw_serial_port supports only 32-bit frames");
      end
   endgenerate

   function automatic logic isMapped(input srw_addr_t addr);
      case (addr)
         `SRW_ADDR_CAL, `SRW_ADDR_CFG, `SRW_ADDR_IOFS, `SRW_ADDR_IGAIN,
         `SRW_ADDR_EXTCFG, `SRW_ADDR_QOFS, `SRW_ADDR_QGAIN,
         `SRW_ADDR_FINE, `SRW_ADDR_COARSE: isMapped = 1'b1;
         default:                          isMapped = 1'b0;
      endcase
   endfunction

   function automatic srw_word_t defaultOf(input srw_addr_t addr);
      case (addr)
         `SRW_ADDR_CAL:    defaultOf = `SRW_DEF_CAL;
         `SRW_ADDR_CFG:    defaultOf = `SRW_DEF_CFG;
         `SRW_ADDR_IOFS:   defaultOf = `SRW_DEF_OFS;
         `SRW_ADDR_IGAIN:  defaultOf = `SRW_DEF_GAIN;
         `SRW_ADDR_EXTCFG: defaultOf = `SRW_DEF_EXTCFG;
         `SRW_ADDR_QOFS:   defaultOf = `SRW_DEF_OFS;
         `SRW_ADDR_QGAIN:  defaultOf = `SRW_DEF_GAIN;
         `SRW_ADDR_FINE:   defaultOf = `SRW_DEF_FINE;
         `SRW_ADDR_COARSE: defaultOf = `SRW_DEF_COARSE;
         default:          defaultOf = `SRW_DEF_NONE;
      endcase
   endfunction

   srw_frame_t  frameWord;
   logic        frameToggle;
   logic        toggleMeta;
   logic        toggleSync;
   logic        toggleSeen;
   logic        framePulse;
   logic        extMeta;
   logic        extSync;
   logic        edgeMeta;
   logic        edgeSync;
   logic        swingMeta;
   logic        swingSync;
   srw_mode_e   mode;
   srw_mode_e   next_mode;
   srw_addr_t   frameAddr;
   srw_word_t   frameData;
   logic        acceptWrite;
   srw_word_t   regFile [0:15];
   srw_word_t   cfgWord;
   srw_word_t   iOfsWord;
   srw_word_t   iGainWord;
   srw_word_t   qOfsWord;
   srw_word_t   qGainWord;
   srw_word_t   fineWord;
   logic        inExt;

   // Link-side receiver on the host's shift clock
   srw_shift_rx #(
      .FRAME_BITS  (FRAME_BITS)
   ) uShiftRx (
      .shiftClk    (shiftClk),
      .rst_n       (rst_n),
      .portSelectN (portSelectN),
      .shiftDataIn (shiftDataIn),
      .frameWord   (frameWord),
      .frameToggle (frameToggle)
   );

   // Frame event crossing; the word is stable for a full frame after the toggle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         toggleMeta <= 1'b0;
         toggleSync <= 1'b0;
         toggleSeen <= 1'b0;
      end else begin
         toggleMeta <= frameToggle;
         toggleSync <= toggleMeta;
         toggleSeen <= toggleSync;
      end
   end

   assign framePulse = toggleSync ^ toggleSeen;
   assign frameAddr  = frameWord[`SRW_ADDR_MSB:`SRW_ADDR_LSB];
   assign frameData  = frameWord[`SRW_DATA_MSB:`SRW_DATA_LSB];

   // Mode and pin synchronisers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         extMeta   <= 1'b0;
         extSync   <= 1'b0;
         edgeMeta  <= 1'b0;
         edgeSync  <= 1'b0;
         swingMeta <= 1'b1;
         swingSync <= 1'b1;
      end else begin
         extMeta   <= ~extendedCtrlN;
         extSync   <= extMeta;
         edgeMeta  <= edgeSelectPin;
         edgeSync  <= edgeMeta;
         swingMeta <= swingSelectPin;
         swingSync <= swingMeta;
      end
   end

   // Control mode sequence
   always_comb begin
      next_mode = mode;
      unique case (mode)
         SRW_MODE_PIN: begin
            if (extSync) begin
               next_mode = SRW_MODE_LOAD;
            end
         end
         SRW_MODE_LOAD: begin
            next_mode = SRW_MODE_EXT;
         end
         SRW_MODE_EXT: begin
            if (!extSync) begin
               next_mode = SRW_MODE_PIN;
            end
         end
         default: begin
            next_mode = SRW_MODE_PIN;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mode <= SRW_MODE_PIN;
      end else begin
         mode <= next_mode;
      end
   end

   assign inExt       = (mode == SRW_MODE_EXT);
   assign acceptWrite = inExt && framePulse;

   // Register storage; calibration bit is a command, never stored
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 16; i++) begin
            regFile[i] <= defaultOf(srw_addr_t'(i));
         end
      end else if (mode == SRW_MODE_LOAD) begin
         for (int i = 0; i < 16; i++) begin
            regFile[i] <= defaultOf(srw_addr_t'(i));
         end
      end else if (acceptWrite && isMapped(frameAddr)) begin
         if (frameAddr != `SRW_ADDR_CAL) begin
            regFile[frameAddr] <= frameData;
         end
      end
   end

   // Calibration command pulse
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         calStart <= 1'b0;
      end else begin
         calStart <= acceptWrite && frameAddr == `SRW_ADDR_CAL
                     && frameData[`SRW_CAL_START_BIT];
      end
   end

   // Write completion pulse for mapped addresses
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         writeDone <= 1'b0;
      end else begin
         writeDone <= acceptWrite && isMapped(frameAddr);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         extendedActive <= 1'b0;
      end else begin
         extendedActive <= inExt;
      end
   end

   // Words in effect: registers in extended mode, defaults otherwise
   assign cfgWord   = inExt ? regFile[`SRW_ADDR_CFG]   : `SRW_DEF_CFG;
   assign iOfsWord  = inExt ? regFile[`SRW_ADDR_IOFS]  : `SRW_DEF_OFS;
   assign iGainWord = inExt ? regFile[`SRW_ADDR_IGAIN] : `SRW_DEF_GAIN;
   assign qOfsWord  = inExt ? regFile[`SRW_ADDR_QOFS]  : `SRW_DEF_OFS;
   assign qGainWord = inExt ? regFile[`SRW_ADDR_QGAIN] : `SRW_DEF_GAIN;
   assign fineWord  = inExt ? regFile[`SRW_ADDR_FINE]  : `SRW_DEF_FINE;

   // Output clock arrangement
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         singleOutclkSel  <= 1'b1;
         dutyStabilizerEn <= 1'b1;
      end else begin
         singleOutclkSel  <= cfgWord[`SRW_CFG_OUTCLK_BIT];
         dutyStabilizerEn <= cfgWord[`SRW_CFG_DUTY_BIT];
      end
   end

   // Data rate and phase; phase only matters in double-rate mode
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         singleRateSel      <= 1'b0;
         doubleRateClkPhase <= 1'b0;
      end else begin
         singleRateSel      <= cfgWord[`SRW_CFG_SDR_BIT];
         doubleRateClkPhase <= cfgWord[`SRW_CFG_PHASE_BIT]
                               & ~cfgWord[`SRW_CFG_SDR_BIT];
      end
   end

   // Swing follows its pin outside extended mode
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         outputSwingSel <= 1'b1;
      end else if (inExt) begin
         outputSwingSel <= cfgWord[`SRW_CFG_SWING_BIT];
      end else begin
         outputSwingSel <= swingSync;
      end
   end

   // Edge select in single rate, demultiplex select in double rate
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         edgeDemuxSel <= 1'b0;
      end else if (inExt) begin
         edgeDemuxSel <= cfgWord[`SRW_CFG_EDGE_BIT];
      end else begin
         edgeDemuxSel <= edgeSync;
      end
   end

   // I channel offset and gain
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         iOffsetMag  <= 8'h00;
         iOffsetNeg  <= 1'b0;
         iGainAdjust <= 9'h100;
      end else begin
         iOffsetMag  <= iOfsWord[`SRW_OFS_MAG_MSB:`SRW_OFS_MAG_LSB];
         iOffsetNeg  <= iOfsWord[`SRW_OFS_SIGN_BIT];
         iGainAdjust <= iGainWord[`SRW_GAIN_MSB:`SRW_GAIN_LSB];
      end
   end

   // Q channel offset and gain
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         qOffsetMag  <= 8'h00;
         qOffsetNeg  <= 1'b0;
         qGainAdjust <= 9'h100;
      end else begin
         qOffsetMag  <= qOfsWord[`SRW_OFS_MAG_MSB:`SRW_OFS_MAG_LSB];
         qOffsetNeg  <= qOfsWord[`SRW_OFS_SIGN_BIT];
         qGainAdjust <= qGainWord[`SRW_GAIN_MSB:`SRW_GAIN_LSB];
      end
   end

   // Extended configuration and sample clock phase
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         extConfigWord   <= `SRW_DEF_EXTCFG;
         phaseFine       <= 8'h00;
         phaseCoarseWord <= `SRW_DEF_COARSE;
      end else begin
         extConfigWord   <= inExt ? regFile[`SRW_ADDR_EXTCFG] : `SRW_DEF_EXTCFG;
         phaseFine       <= fineWord[`SRW_FINE_MSB:`SRW_FINE_LSB];
         phaseCoarseWord <= inExt ? regFile[`SRW_ADDR_COARSE] : `SRW_DEF_COARSE;
      end
   end
endmodule // srw_serial_port

`default_nettype wire

// ### srw_serial_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module srw_serial_port_chk
   import srw_pkg::*;
#(
   parameter int FRAME_BITS = 32
) (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       rst_n,
   // Pin-mode input
   input wire logic       swingSelectPin,
   // Watched outputs
   input wire logic       calStart,
   input wire logic       singleOutclkSel,
   input wire logic       dutyStabilizerEn,
   input wire logic       doubleRateClkPhase,
   input wire logic       singleRateSel,
   input wire logic       outputSwingSel,
   input wire logic [7:0] iOffsetMag,
   input wire logic       iOffsetNeg,
   input wire logic [8:0] iGainAdjust,
   input wire logic [8:0] qGainAdjust,
   input wire srw_word_t  extConfigWord,
   input wire logic [7:0] phaseFine,
   input wire srw_word_t  phaseCoarseWord,
   input wire logic       extendedActive,
   input wire logic       writeDone
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_cal_pulse; calStart |=> !calStart; endproperty
   a_cal_pulse: assert property (p_cal_pulse) else $error("calStart longer than one cycle");
   property p_cal_done; calStart |-> writeDone; endproperty
   a_cal_done: assert property (p_cal_done) else $error("calStart without accepted frame");
   property p_done_ext; writeDone |-> extendedActive; endproperty
   a_done_ext: assert property (p_done_ext) else $error("write accepted outside extended mode");
   property p_done_pulse; writeDone |=> !writeDone; endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("writeDone longer than one cycle");
   property p_pin_defaults;
      !extendedActive [*3] |-> singleOutclkSel && dutyStabilizerEn && !doubleRateClkPhase
         && !singleRateSel && iOffsetMag == 8'h00 && !iOffsetNeg && iGainAdjust == 9'h100
         && qGainAdjust == 9'h100 && extConfigWord == 16'h03FF && phaseFine == 8'h00;
   endproperty
   a_pin_defaults: assert property (p_pin_defaults) else $error("register effect in pin mode");
   property p_phase_ddr; doubleRateClkPhase |-> !singleRateSel; endproperty
   a_phase_ddr: assert property (p_phase_ddr) else $error("clock phase set in single rate");
   property p_change_after_write;
      extendedActive && $past(extendedActive, 2) && ($changed(iOffsetMag) || $changed(singleRateSel))
         |-> $past(writeDone);
   endproperty
   a_change_after_write: assert property (p_change_after_write) else $error("output changed without write");
   property p_swing_pin;
      ($stable(swingSelectPin) && !extendedActive) [*5] |-> outputSwingSel == swingSelectPin;
   endproperty
   a_swing_pin: assert property (p_swing_pin) else $error("swing does not follow pin");
   property p_load_defaults;
      $rose(extendedActive) |-> iOffsetMag == 8'h00 && iGainAdjust == 9'h100 && singleOutclkSel
         && extConfigWord == 16'h03FF && phaseCoarseWord == 16'h007F && phaseFine == 8'h00;
   endproperty
   a_load_defaults: assert property (p_load_defaults) else $error("defaults not loaded on entry");
endmodule // srw_serial_port_chk

bind srw_serial_port srw_serial_port_chk #(.FRAME_BITS(FRAME_BITS)) u_chk (.clk_sys, .rst_n,
   .swingSelectPin, .calStart, .singleOutclkSel, .dutyStabilizerEn, .doubleRateClkPhase,
   .singleRateSel, .outputSwingSel, .iOffsetMag, .iOffsetNeg, .iGainAdjust, .qGainAdjust,
   .extConfigWord, .phaseFine, .phaseCoarseWord, .extendedActive, .writeDone);
`default_nettype wire

// ### srw_shift_rx.sv
`timescale 1ns/1ps
`default_nettype none
`include "srw_params.svh"

module srw_shift_rx #(
   parameter int FRAME_BITS = `SRW_FRAME_BITS
) (
   // Link clock and resets
   input  wire logic               shiftClk,
   input  wire logic               rst_n,
   input  wire logic               portSelectN,
   // Serial data
   input  wire logic               shiftDataIn,
   // Completed frame, held until the next good frame
   output logic [FRAME_BITS-13:0]  frameWord,
   output logic                    frameToggle
);
   import srw_pkg::*;

   generate
      if (FRAME_BITS != `SRW_FRAME_BITS) begin : gBadFrame
         $error("srw_shift_rx supports only 32-bit frames");
      end
   endgenerate

   logic                  frameRst_n;
   logic [4:0]            bitCount;
   logic [FRAME_BITS-2:0] shiftReg;
   logic [FRAME_BITS-1:0] fullFrame;

   // A high select aborts any partial frame at once
   assign frameRst_n = rst_n & ~portSelectN;
   assign fullFrame  = {shiftReg, shiftDataIn};

   always_ff @(posedge shiftClk or negedge frameRst_n) begin
      if (!frameRst_n) begin
         bitCount <= 5'h00;
         shiftReg <= '0;
      end else begin
         // Count wraps so the 33rd clock opens the next frame
         bitCount <= bitCount + 5'h01;
         shiftReg <= fullFrame[FRAME_BITS-2:0];
      end
   end

   always_ff @(posedge shiftClk or negedge rst_n) begin
      if (!rst_n) begin
         frameWord   <= '0;
         frameToggle <= 1'b0;
      end else if (!portSelectN && bitCount == 5'h1F) begin
         if (fullFrame[`SRW_HEADER_MSB:`SRW_HEADER_LSB] == `SRW_HEADER) begin
            frameWord   <= fullFrame[`SRW_ADDR_MSB:`SRW_DATA_LSB];
            frameToggle <= ~frameToggle;
         end
      end
   end
endmodule // srw_shift_rx

`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "srw_params.svh"
module tb;
   import srw_pkg::*;
   logic       clk_sys, rst_n, extendedCtrlN, edgeSelectPin, swingSelectPin;
   wire logic  shiftClk, shiftDataIn, portSelectN;
   logic       calStart, singleOutclkSel, dutyStabilizerEn, doubleRateClkPhase, singleRateSel;
   logic       outputSwingSel, edgeDemuxSel, iOffsetNeg, qOffsetNeg, extendedActive, writeDone;
   logic [7:0] iOffsetMag, qOffsetMag, phaseFine;
   logic [8:0] iGainAdjust, qGainAdjust;
   srw_word_t  extConfigWord, phaseCoarseWord;
   int         n_mismatch = 0, tests_run = 0, nWd = 0, nCal = 0;
   wire logic [5:0] cfgSeen = {singleOutclkSel, dutyStabilizerEn, doubleRateClkPhase,
                               singleRateSel, outputSwingSel, edgeDemuxSel};

   srw_host_model host (.shiftClk, .shiftDataIn, .portSelectN);
   srw_serial_port #(.FRAME_BITS(32)) dut (.clk_sys, .rst_n, .shiftClk, .shiftDataIn,
      .portSelectN, .extendedCtrlN, .edgeSelectPin, .swingSelectPin, .calStart,
      .singleOutclkSel, .dutyStabilizerEn, .doubleRateClkPhase, .singleRateSel,
      .outputSwingSel, .edgeDemuxSel, .iOffsetMag, .iOffsetNeg, .iGainAdjust, .qOffsetMag,
      .qOffsetNeg, .qGainAdjust, .extConfigWord, .phaseFine, .phaseCoarseWord,
      .extendedActive, .writeDone);

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (writeDone === 1'b1) nWd++;
      if (calStart === 1'b1) nCal++;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   function automatic logic [5:0] cfg_exp(input srw_word_t d);
      return {d[13], d[12], d[11] & ~d[10], d[10], d[9], d[8]};
   endfunction
   function automatic logic [31:0] frm(input srw_addr_t a, input srw_word_t d);
      return {`SRW_HEADER, a, d};
   endfunction
   // Waits a bounded time for the expected number of accepted frames
   task automatic settle(input int want);
      for (int i = 0; i < 40 && nWd < want; i++) @(posedge clk_sys);
      repeat (8) @(posedge clk_sys);
      chk(nWd, want);
      if (nWd != want) tally_and_finish();
      #1;
   endtask
   task automatic wr(input srw_addr_t a, input srw_word_t d, input int done);
      int base;
      base = nWd;
      host.send({32'h0, frm(a, d)}, 32, 1'b0);
      settle(base + done);
   endtask
   task automatic wait_ext(input logic lvl);
      for (int i = 0; i < 40 && extendedActive !== lvl; i++) @(posedge clk_sys);
      chk(extendedActive, lvl);
      if (extendedActive !== lvl) tally_and_finish();
      #1;
   endtask

   task automatic t_pin_mode();
      chk(cfgSeen, 6'b110010);
      swingSelectPin = 1'b0;
      edgeSelectPin = 1'b1;
      repeat (6) @(posedge clk_sys);
      chk(cfgSeen, 6'b110001);
      #1 wr(`SRW_ADDR_IOFS, 16'hA5FF, 0);
      chk(iOffsetMag, 8'h00);
      swingSelectPin = 1'b1;
      edgeSelectPin = 1'b0;
      repeat (6) @(posedge clk_sys);
      #1 $display("pin mode test done");
   endtask
   task automatic t_enter();
      extendedCtrlN = 1'b0;
      wait_ext(1'b1);
      chk(cfgSeen, 6'b110010);
      chk({iGainAdjust, qGainAdjust}, {9'h100, 9'h100});
      chk({extConfigWord, phaseCoarseWord}, 32'h03FF_007F);
      $display("entry defaults test done");
   endtask
   task automatic t_config();
      srw_word_t tab[4] = '{16'h80FF, 16'hBBFF, 16'hA9FF, 16'h9EFF};
      foreach (tab[i]) begin
         wr(`SRW_ADDR_CFG, tab[i], 1);
         chk(cfgSeen, cfg_exp(tab[i]));
      end
      $display("configuration test done");
   endtask
   task automatic t_regs();
      int base;
      base = nWd;
      host.send({frm(`SRW_ADDR_IOFS, 16'hA5FF), frm(`SRW_ADDR_IGAIN, 16'hC1FF)}, 64, 1'b1);
      host.send({frm(`SRW_ADDR_QOFS, 16'h3C7F), frm(`SRW_ADDR_QGAIN, 16'h40FF)}, 64, 1'b1);
      host.send({frm(`SRW_ADDR_EXTCFG, 16'hE7FF), frm(`SRW_ADDR_FINE, 16'h5AFF)}, 64, 1'b1);
      host.send({32'h0, frm(`SRW_ADDR_COARSE, 16'hC47F)}, 32, 1'b0);
      settle(base + 7);
      chk({iOffsetMag, iOffsetNeg, iGainAdjust}, {8'hA5, 1'b1, 9'h183});
      chk({qOffsetMag, qOffsetNeg, qGainAdjust}, {8'h3C, 1'b0, 9'h081});
      chk({extConfigWord, phaseCoarseWord}, 32'hE7FF_C47F);
      chk(phaseFine, 8'h5A);
      $display("register map test done");
   endtask
   task automatic t_cal();
      int base;
      base = nCal;
      wr(`SRW_ADDR_CAL, 16'hFFFF, 1);
      chk(nCal, base + 1);
      // Keep the line quiet while the started calibration runs
      repeat (40) @(posedge clk_sys);
      #1 wr(`SRW_ADDR_CAL, 16'h7FFF, 1);
      chk(nCal, base + 1);
      $display("calibration test done");
   endtask
   task automatic t_refuse();
      srw_addr_t rsv[7] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hC, 4'hD};
      int base;
      // Count taken before sending, so a wrongly accepted frame shows
      base = nWd;
      host.send({32'h0, 12'h002, `SRW_ADDR_IOFS, 16'h00FF}, 32, 1'b0);
      settle(base);
      foreach (rsv[i]) wr(rsv[i], 16'h00FF, 0);
      base = nWd;
      host.send({32'h0, frm(`SRW_ADDR_IOFS, 16'h00FF)} >> 12, 20, 1'b0);
      settle(base);
      chk({iOffsetMag, iOffsetNeg}, {8'hA5, 1'b1});
      wr(`SRW_ADDR_IOFS, 16'h117F, 1);
      chk({iOffsetMag, iOffsetNeg}, {8'h11, 1'b0});
      $display("refusal test done");
   endtask
   task automatic t_reenter();
      extendedCtrlN = 1'b1;
      wait_ext(1'b0);
      repeat (4) @(posedge clk_sys);
      chk(cfgSeen, 6'b110010);
      chk(iOffsetMag, 8'h00);
      #1 extendedCtrlN = 1'b0;
      wait_ext(1'b1);
      chk({iOffsetMag, phaseFine}, 16'h0000);
      chk(phaseCoarseWord, 16'h007F);
      $display("re-entry test done");
   endtask

   initial begin
      rst_n = 1'b0;
      extendedCtrlN = 1'b1;
      edgeSelectPin = 1'b0;
      swingSelectPin = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 t_pin_mode();
      t_enter();
      t_config();
      t_regs();
      t_cal();
      t_refuse();
      t_reenter();
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
